// ===== bus_trigger.v
// passive two-wire bus trigger matcher with register port and interrupt
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`include "trig_map.vh"
module bus_trigger (
    // clock and reset
    input wire clock,
    input wire rstn,
    // observed inputs, four analog samples of eight bits
    input wire [31:0] analog_in,
    input wire [15:0] digital_in,
    // register port
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    // outputs
    output reg trigger,
    output wire irq
);
    reg rst_a_reg, rst_b_reg;
    wire reset_n = rst_b_reg;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_a_reg <= 1'b0;
            rst_b_reg <= 1'b0;
        end else begin
            rst_a_reg <= 1'b1;
            rst_b_reg <= rst_a_reg;
        end
    end

    reg [4:0] clock_line_source_reg, data_line_source_reg;
    reg [7:0] clock_thr_reg, data_thr_reg;
    reg [3:0] condition_reg;
    reg [10:0] address_reg;
    reg [8:0] first_byte_reg, second_byte_reg;
    reg [1:0] relation_reg, direction_reg;
    reg addr_width_reg;
    reg [3:0] byte_count_reg;
    reg [3:0] status_reg, mask_reg;

    wire scl, sda;
    line_slicer clock_slicer (
        .clock(clock), .reset_n(reset_n), .analog_in(analog_in),
        .digital_in(digital_in), .source(clock_line_source_reg),
        .threshold(clock_thr_reg), .level(scl)
    );
    line_slicer data_slicer (
        .clock(clock), .reset_n(reset_n), .analog_in(analog_in),
        .digital_in(digital_in), .source(data_line_source_reg),
        .threshold(data_thr_reg), .level(sda)
    );

    reg scl_d_reg, sda_d_reg;
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl;
            sda_d_reg <= sda;
        end
    end
    wire start_ev = scl && scl_d_reg && sda_d_reg && !sda;
    wire stop_ev = scl && scl_d_reg && !sda_d_reg && sda;
    wire scl_rise = scl && !scl_d_reg;

    function byte_ok;
        input [8:0] cmp;
        input [7:0] seen;
        begin
            byte_ok = (cmp == `BYTE_ANY) || (cmp[7:0] == seen);
        end
    endfunction

    function dir_ok;
        input [1:0] filt;
        input rw;
        begin
            case (filt)
                `DIR_READ: dir_ok = rw;
                `DIR_WRITE: dir_ok = !rw;
                default: dir_ok = 1'b1;
            endcase
        end
    endfunction

    // frame parser: bit counter, byte index, shift register
    reg [3:0] bit_cnt_reg;
    reg [3:0] byte_idx_reg;
    reg [7:0] shift_reg;
    reg in_frame_reg;
    reg rw_reg;
    reg [9:0] addr_seen_reg;
    reg [7:0] data1_reg;
    reg frame_ok_reg;
    reg ten_reg;
    reg [3:0] data_cnt_reg;
    reg hit_frame;
    reg missing_acknowledge_event_ev;
    wire [7:0] byte_now = {shift_reg[6:0], sda};
    wire ten_mode = (condition_reg == `COND_ADDR10) ||
                    (condition_reg == `COND_LENGTH && addr_width_reg);
    wire [3:0] hdr_bytes = ten_mode ? 4'h2 : 4'h1;

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 4'h0;
            shift_reg <= 8'h00;
            in_frame_reg <= 1'b0;
            rw_reg <= 1'b0;
            addr_seen_reg <= 10'h000;
            data1_reg <= 8'h00;
            frame_ok_reg <= 1'b0;
            ten_reg <= 1'b0;
            data_cnt_reg <= 4'h0;
        end else if (start_ev) begin
            in_frame_reg <= 1'b1;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= 4'h0;
            data_cnt_reg <= 4'h0;
            frame_ok_reg <= 1'b1;
            ten_reg <= ten_mode;
        end else if (stop_ev) begin
            in_frame_reg <= 1'b0;
        end else if (in_frame_reg && scl_rise) begin
            if (bit_cnt_reg == 4'h8) begin
                bit_cnt_reg <= 4'h0;
                byte_idx_reg <= byte_idx_reg + 4'h1;
                if (byte_idx_reg >= hdr_bytes && sda == 1'b0)
                    data_cnt_reg <= data_cnt_reg + 4'h1;
                if (sda)
                    frame_ok_reg <= 1'b0;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                shift_reg <= byte_now;
                if (bit_cnt_reg == 4'h7) begin
                    if (byte_idx_reg == 4'h0) begin
                        rw_reg <= byte_now[0];
                        if (ten_reg)
                            addr_seen_reg[9:8] <= byte_now[2:1];
                        else
                            addr_seen_reg <= {3'h0, byte_now[7:1]};
                    end else if (byte_idx_reg == 4'h1 && ten_reg) begin
                        addr_seen_reg[7:0] <= byte_now;
                    end else if (byte_idx_reg == hdr_bytes) begin
                        data1_reg <= byte_now;
                    end
                end
            end
        end
    end

    // frame match evaluated at the ninth clock of the last byte it needs, the length match at the stop
    wire addr_ok = ten_reg ?
        (address_reg == `ADDR10_ANY || address_reg[9:0] == addr_seen_reg) :
        (address_reg == `ADDR7_ANY || address_reg[6:0] == addr_seen_reg[6:0]);
    wire ack_clk = in_frame_reg && scl_rise && bit_cnt_reg == 4'h8;
    reg rel_ok;
    always @* begin
        case (relation_reg)
            `REL_GREATER: rel_ok = data1_reg > first_byte_reg[7:0];
            `REL_LESS: rel_ok = data1_reg < first_byte_reg[7:0];
            default: rel_ok = data1_reg == first_byte_reg[7:0];
        endcase
        if (first_byte_reg == `BYTE_ANY)
            rel_ok = 1'b1;
    end

    always @* begin
        hit_frame = 1'b0;
        missing_acknowledge_event_ev = ack_clk && sda;
        case (condition_reg)
            `COND_MEMORY:
                hit_frame = ack_clk && !sda && byte_idx_reg == 4'h1 &&
                            rw_reg && frame_ok_reg && rel_ok;
            `COND_ADDR7, `COND_ADDR10:
                hit_frame = ack_clk && !sda && frame_ok_reg &&
                            byte_idx_reg == hdr_bytes + 4'h1 && addr_ok &&
                            dir_ok(direction_reg, rw_reg) &&
                            byte_ok(first_byte_reg, data1_reg) &&
                            byte_ok(second_byte_reg, shift_reg);
            `COND_LENGTH:
                hit_frame = stop_ev && in_frame_reg &&
                            data_cnt_reg == byte_count_reg &&
                            dir_ok(direction_reg, rw_reg);
            default: hit_frame = 1'b0;
        endcase
    end

    reg hit;
    always @* begin
        case (condition_reg)
            `COND_START: hit = start_ev;
            `COND_STOP: hit = stop_ev;
            `COND_RESTART: hit = start_ev && in_frame_reg;
            `COND_MISSING_ACKNOWLEDGE_EVENT: hit = missing_acknowledge_event_ev;
            default: hit = hit_frame;
        endcase
    end

    // register writes, sticky status set wins over write-one clear
    wire [3:0] events = {missing_acknowledge_event_ev, stop_ev, start_ev, hit};
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            clock_line_source_reg <= 5'h00;
            data_line_source_reg <= 5'h01;
            clock_thr_reg <= `RST_THR;
            data_thr_reg <= `RST_THR;
            condition_reg <= `COND_START;
            address_reg <= `RST_ADDR;
            first_byte_reg <= `RST_BYTE;
            second_byte_reg <= `RST_BYTE;
            relation_reg <= `REL_EQUAL;
            direction_reg <= `DIR_EITHER;
            addr_width_reg <= 1'b0;
            byte_count_reg <= `RST_COUNT;
            status_reg <= 4'h0;
            mask_reg <= 4'h0;
            trigger <= 1'b0;
        end else begin
            trigger <= hit;
            if (wr) begin
                case (addr)
                    `OFF_CLOCK_SRC: clock_line_source_reg <= wdata[4:0];
                    `OFF_DATA_SRC: data_line_source_reg <= wdata[4:0];
                    `OFF_CLOCK_THR: clock_thr_reg <= wdata[7:0];
                    `OFF_DATA_THR: data_thr_reg <= wdata[7:0];
                    `OFF_CONDITION: condition_reg <= wdata[3:0];
                    `OFF_ADDRESS: address_reg <= wdata[10:0];
                    `OFF_FIRST_BYTE: first_byte_reg <= wdata[8:0];
                    `OFF_SECOND_BYTE: second_byte_reg <= wdata[8:0];
                    `OFF_RELATION: relation_reg <= wdata[1:0];
                    `OFF_DIRECTION: direction_reg <= wdata[1:0];
                    `OFF_ADDR_WIDTH: addr_width_reg <= wdata[0];
                    `OFF_BYTE_COUNT: begin
                        // out-of-range lengths are clamped to the legal span
                        if (wdata[15:4] != 12'h000 || wdata[3:0] > `COUNT_MAX)
                            byte_count_reg <= `COUNT_MAX;
                        else if (wdata[3:0] < `COUNT_MIN)
                            byte_count_reg <= `COUNT_MIN;
                        else
                            byte_count_reg <= wdata[3:0];
                    end
                    `OFF_MASK: mask_reg <= wdata[3:0];
                    default: ;
                endcase
            end
            if (wr && addr == `OFF_STATUS)
                status_reg <= (status_reg & ~wdata[3:0]) | events;
            else
                status_reg <= status_reg | events;
        end
    end
    assign irq = |(status_reg & mask_reg);

    // read port, data stand one cycle after the strobe
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `OFF_CLOCK_SRC: rdata <= {11'h000, clock_line_source_reg};
                `OFF_DATA_SRC: rdata <= {11'h000, data_line_source_reg};
                `OFF_CLOCK_THR: rdata <= {8'h00, clock_thr_reg};
                `OFF_DATA_THR: rdata <= {8'h00, data_thr_reg};
                `OFF_CONDITION: rdata <= {12'h000, condition_reg};
                `OFF_ADDRESS: rdata <= {5'h00, address_reg};
                `OFF_FIRST_BYTE: rdata <= {7'h00, first_byte_reg};
                `OFF_SECOND_BYTE: rdata <= {7'h00, second_byte_reg};
                `OFF_RELATION: rdata <= {14'h0000, relation_reg};
                `OFF_DIRECTION: rdata <= {14'h0000, direction_reg};
                `OFF_ADDR_WIDTH: rdata <= {15'h0000, addr_width_reg};
                `OFF_BYTE_COUNT: rdata <= {12'h000, byte_count_reg};
                `OFF_STATUS: rdata <= {12'h000, status_reg};
                `OFF_MASK: rdata <= {12'h000, mask_reg};
                default: rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule // bus_trigger

// ===== line_slicer.v
// source selection, threshold slicing and two-stage sync for one bus line
`timescale 1ns/1ns
module line_slicer (
    // clock and reset
    input wire clock,
    input wire reset_n,
    // inputs
    input wire [31:0] analog_in,
    input wire [15:0] digital_in,
    input wire [4:0] source,
    input wire [7:0] threshold,
    // sliced level
    output reg level
);
    reg [31:0] analog_meta_reg;
    reg [31:0] analog_sync_reg;
    reg [15:0] digital_meta_reg;
    reg [15:0] digital_sync_reg;
    wire [1:0] chan = source[1:0];
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            // idle high on every source, so no false edge follows reset
            analog_meta_reg <= 32'hFFFFFFFF;
            analog_sync_reg <= 32'hFFFFFFFF;
            digital_meta_reg <= 16'hFFFF;
            digital_sync_reg <= 16'hFFFF;
            level <= 1'b1;
        end else begin
            // both sync stages sit ahead of the mux so it never sees a metastable bit
            analog_meta_reg <= analog_in;
            analog_sync_reg <= analog_meta_reg;
            digital_meta_reg <= digital_in;
            digital_sync_reg <= digital_meta_reg;
            // analog codes sit above the sixteen digital lines
            if (source[`SRC_ANALOG_BIT])
                level <= analog_sync_reg[chan*8 +: 8] >= threshold;
            else
                level <= digital_sync_reg[source[3:0]];
        end
    end
endmodule // line_slicer

// ===== tb_top.sv
// self-checking bench for the bus trigger matcher
`timescale 1ns/1ns
`include "trig_map.vh"
module tb_top;
    logic clock, rstn, wr, rd, trigger, irq;
    logic [31:0] analog_in;
    logic [15:0] digital_in, wdata, rdata, v;
    logic [3:0] addr;
    wire scl, sda;
    int n_mismatch, num_checks, n_trig;
    two_wire_model bus (.scl(scl), .sda(sda));
    bus_trigger DUT (.clock(clock), .rstn(rstn), .analog_in(analog_in),
        .digital_in(digital_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .trigger(trigger), .irq(irq));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // lines 0/1 and 14/15 carry the bus; analog ch0 mirrors the clock line
    always @(posedge clock) begin
        digital_in <= {sda, scl, 12'h000, sda, scl};
        analog_in <= {24'h000000, scl ? 8'hC0 : 8'h40};
        if (trigger === 1'b1) n_trig <= n_trig + 1;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_now();
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        v = rdata;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd_now();
    endtask
    // write and read straight back, read strobe right behind the write
    task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
        wr_reg(a, d);
        rd_now();
        check(v, e);
    endtask
    task automatic cfg(input logic [15:0] c, ad, d1, d2, rel, dir, wid, cnt);
        logic [15:0] val [8];
        val = '{c, ad, d1, d2, rel, dir, wid, cnt};
        for (int i = 0; i < 8; i++) wr_rd(4'(i + 4), val[i], val[i]);
    endtask
    task automatic run(input logic [31:0] b, input int n, input logic nk, rs, input int exp);
        int base;
        // line moves then fall on falling clock edges, clear of the sampling edge
        @(negedge clock);
        base = n_trig;
        bus.bus_start();
        for (int i = 0; i < n; i++) begin
            bus.put_byte(b[31 - 8 * i -: 8], nk && i == n - 1);
            if (rs && i == 0) bus.bus_start();
        end
        bus.bus_stop();
        repeat (20) @(posedge clock);
        check(16'(n_trig - base), 16'(exp));
    endtask
    task automatic t_regs();
        logic [15:0] rst_val [16];
        rst_val = '{0, 1, 16'h80, 16'h80, 0, 16'h80, 16'h100, 16'h100, 0, 2, 0, 1, 0, 0, 0, 0};
        wr_reg(4'hE, 16'hFFFF);
        for (int i = 0; i < 16; i++) begin
            rd_reg(4'(i));
            check(v, rst_val[i]);
        end
        wr_rd(`OFF_BYTE_COUNT, 16'h0000, 16'h0001);
        wr_rd(`OFF_BYTE_COUNT, 16'h000D, 16'h000C);
        wr_rd(`OFF_BYTE_COUNT, 16'h0010, 16'h000C);
    endtask
    task automatic t_events();
        wr_rd(`OFF_CONDITION, `COND_START, `COND_START);
        run(32'hA0000000, 1, 0, 0, 1);
        wr_rd(`OFF_CONDITION, `COND_STOP, `COND_STOP);
        run(32'hA0000000, 1, 0, 0, 1);
        wr_rd(`OFF_CONDITION, `COND_RESTART, `COND_RESTART);
        run(32'hA0A10000, 2, 0, 1, 1);
        run(32'hA0A10000, 2, 0, 0, 0);
        wr_rd(`OFF_CONDITION, `COND_MISSING_ACKNOWLEDGE_EVENT, `COND_MISSING_ACKNOWLEDGE_EVENT);
        run(32'hA0000000, 1, 0, 0, 0);
        wr_reg(`OFF_STATUS, 16'h000F);
        run(32'hA0000000, 1, 1, 0, 1);
        rd_reg(`OFF_STATUS);
        check(v, 16'h000F);
        check(irq, 1'b0);
        wr_reg(`OFF_MASK, 16'h0008);
        @(negedge clock);
        check(irq, 1'b1);
        wr_reg(`OFF_MASK, 16'h0000);
        wr_reg(`OFF_MASK, 16'h000F);
        wr_reg(`OFF_STATUS, 16'h000F);
        @(negedge clock);
        check(irq, 1'b0);
    endtask
    task automatic t_addr();
        cfg(`COND_ADDR7, 16'h050, 16'h011, 16'h022, 0, `DIR_EITHER, 0, 1);
        run(32'hA0112200, 3, 0, 0, 1);
        run(32'hA0112300, 3, 0, 0, 0);
        run(32'hA0112200, 3, 1, 0, 0);
        cfg(`COND_ADDR7, 16'h080, 16'h100, 16'h100, 0, `DIR_READ, 0, 1);
        run(32'hA0334400, 3, 0, 0, 0);
        run(32'h17334400, 3, 0, 0, 1);
        cfg(`COND_ADDR10, 16'h122, 16'h029, 16'h100, 0, `DIR_WRITE, 0, 1);
        run(32'hF2222977, 4, 0, 0, 1);
        cfg(`COND_ADDR10, 16'h123, 16'h029, 16'h100, 0, `DIR_EITHER, 0, 1);
        run(32'hF2222977, 4, 0, 0, 0);
        cfg(`COND_ADDR10, 16'h400, 16'h029, 16'h100, 0, `DIR_READ, 0, 1);
        run(32'hF3552900, 4, 0, 0, 1);
    endtask
    task automatic t_memory();
        cfg(`COND_MEMORY, 16'h080, 16'h040, 16'h100, `REL_GREATER, `DIR_WRITE, 0, 1);
        run(32'hA1410000, 2, 0, 0, 1);
        run(32'hA0410000, 2, 0, 0, 0);
        wr_rd(`OFF_RELATION, `REL_LESS, `REL_LESS);
        run(32'hA1410000, 2, 0, 0, 0);
        wr_rd(`OFF_RELATION, `REL_EQUAL, `REL_EQUAL);
        run(32'hA1400000, 2, 0, 0, 1);
    endtask
    task automatic t_length();
        cfg(`COND_LENGTH, 16'h080, 16'h100, 16'h100, 0, `DIR_EITHER, 0, 2);
        run(32'hA0112200, 3, 0, 0, 1);
        run(32'hF0001122, 4, 0, 0, 0);
        wr_rd(`OFF_ADDR_WIDTH, 16'h0001, 16'h0001);
        run(32'hF0001122, 4, 0, 0, 1);
        wr_rd(`OFF_BYTE_COUNT, 16'h0003, 16'h0003);
        run(32'hF0001122, 4, 0, 0, 0);
    endtask
    task automatic t_sources();
        wr_rd(`OFF_CONDITION, `COND_START, `COND_START);
        wr_rd(`OFF_CLOCK_SRC, 16'h0010, 16'h0010);
        wr_rd(`OFF_DATA_SRC, 16'h000F, 16'h000F);
        run(32'hA0000000, 1, 0, 0, 1);
        wr_rd(`OFF_CLOCK_THR, 16'h00D0, 16'h00D0);
        run(32'hA0000000, 1, 0, 0, 0);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {wr, rd, addr, wdata, rstn, analog_in} = '0;
        {n_mismatch, num_checks, n_trig} = '0;
        digital_in = 16'hC003;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        t_regs();
        t_events();
        t_addr();
        t_memory();
        t_length();
        t_sources();
        give_verdict();
    end
    // the frames above need well under a millisecond
    initial begin
        #3000000;
        n_mismatch++;
        give_verdict();
    end
endmodule // tb_top

// ===== trig_checker_assertions.sv
// port checker for the bus trigger matcher
`timescale 1ns/1ns
`include "trig_map.vh"
module trig_checker (
    // clock and reset
    input wire clock,
    input wire rstn,
    // pins and register port
    input wire [31:0] analog_in,
    input wire [15:0] digital_in,
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    input wire [15:0] rdata,
    // outputs
    input wire trigger,
    input wire irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    logic [47:0] pins_reg;
    logic [3:0] quiet_reg;
    // a trigger can only trail a pin movement by the synchronizer lag
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pins_reg <= 48'h0;
            quiet_reg <= 4'hF;
        end else begin
            pins_reg <= {analog_in, digital_in};
            quiet_reg <= (pins_reg != {analog_in, digital_in}) ? 4'h0 :
                (quiet_reg == 4'hF) ? 4'hF : quiet_reg + 4'h1;
        end
    end
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside its answer cycle");
    AST_UNMAPPED: assert property (rd && addr > `OFF_MASK |=> rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_COND_READBACK: assert property (
        (wr && addr == `OFF_CONDITION) ##1 (rd && addr == `OFF_CONDITION)
        |=> rdata == ($past(wdata, 2) & 16'h000F)) else $error("condition readback");
    AST_THR_READBACK: assert property (
        (wr && addr == `OFF_CLOCK_THR) ##1 (rd && addr == `OFF_CLOCK_THR)
        |=> rdata == ($past(wdata, 2) & 16'h00FF)) else $error("threshold readback");
    AST_COUNT_CLAMP: assert property (
        (wr && addr == `OFF_BYTE_COUNT) ##1 (rd && addr == `OFF_BYTE_COUNT)
        |=> rdata == (($past(wdata, 2) == 16'h0) ? 16'h0001 :
        ($past(wdata, 2) > 16'h000C) ? 16'h000C : $past(wdata, 2)))
        else $error("byte count not clamped");
    AST_TRIG_PULSE: assert property (trigger |=> !trigger)
        else $error("trigger longer than one cycle");
    AST_TRIG_CAUSE: assert property (trigger |-> quiet_reg < 4'hC)
        else $error("trigger without bus activity");
    AST_MASK_OFF: assert property (
        wr && addr == `OFF_MASK && wdata[3:0] == 4'h0 |=> !irq)
        else $error("interrupt with empty mask");
endmodule // trig_checker
bind bus_trigger trig_checker u_chk (.clock(clock), .rstn(rstn), .analog_in(analog_in),
    .digital_in(digital_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .trigger(trigger), .irq(irq));

// ===== trig_map.vh
// register offsets, field codes and reset values of the bus trigger matcher
`ifndef TRIG_MAP_VH
`define TRIG_MAP_VH
`define OFF_CLOCK_SRC 4'h0
`define OFF_DATA_SRC 4'h1
`define OFF_CLOCK_THR 4'h2
`define OFF_DATA_THR 4'h3
`define OFF_CONDITION 4'h4
`define OFF_ADDRESS 4'h5
`define OFF_FIRST_BYTE 4'h6
`define OFF_SECOND_BYTE 4'h7
`define OFF_RELATION 4'h8
`define OFF_DIRECTION 4'h9
`define OFF_ADDR_WIDTH 4'hA
`define OFF_BYTE_COUNT 4'hB
`define OFF_STATUS 4'hC
`define OFF_MASK 4'hD
`define COND_START 4'h0
`define COND_STOP 4'h1
`define COND_RESTART 4'h2
`define COND_MISSING_ACKNOWLEDGE_EVENT 4'h3
`define COND_MEMORY 4'h4
`define COND_ADDR7 4'h5
`define COND_ADDR10 4'h6
`define COND_LENGTH 4'h7
`define REL_EQUAL 2'h0
`define REL_GREATER 2'h1
`define REL_LESS 2'h2
`define DIR_READ 2'h0
`define DIR_WRITE 2'h1
`define DIR_EITHER 2'h2
`define ADDR7_ANY 11'h080
`define ADDR10_ANY 11'h400
`define BYTE_ANY 9'h100
`define COUNT_MIN 4'h1
`define COUNT_MAX 4'hC
`define SRC_ANALOG_BIT 4
`define ST_TRIG 0
`define ST_START 1
`define ST_STOP 2
`define ST_MISSING_ACKNOWLEDGE_EVENT 3
`define RST_BYTE 9'h100
`define RST_ADDR 11'h080
`define RST_THR 8'h80
`define RST_COUNT 4'h1
`define TEN_BIT_PREFIX 5'h1E
`endif

// ===== two_wire_model.sv
// behavioural two-wire bus controller and target driving both lines
`timescale 1ns/1ns
module two_wire_model (
    // bus lines, pulled up at idle
    output logic scl,
    output logic sda
);
    localparam int HALF = 200;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // data moves only while the clock line is low
    task automatic put_bit(input logic b);
        sda = b;
        #HALF;
        scl = 1'b1;
        #HALF;
        scl = 1'b0;
    endtask
    // called mid-frame this is the repeated start
    task automatic bus_start();
        if (!scl) begin
            sda = 1'b1;
            #HALF;
            scl = 1'b1;
        end
        #HALF;
        sda = 1'b0;
        #HALF;
        scl = 1'b0;
    endtask
    task automatic bus_stop();
        sda = 1'b0;
        #HALF;
        scl = 1'b1;
        #HALF;
        sda = 1'b1;
        #HALF;
    endtask
    task automatic put_byte(input logic [7:0] b, input logic nack);
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
        put_bit(nack);
    endtask
endmodule // two_wire_model
